// ---- pkg/ssdb_params.svh ----
/*
 * Constants of the suspend source and doorbell register bank.
 * Assumes inclusion by bare name from the pkg folder on the include path.
 */
`ifndef SSDB_PARAMS_SVH
`define SSDB_PARAMS_SVH

// ************************************************************
// Register offsets (byte addresses, word aligned)
// ************************************************************
`define SSDB_OFS_SUSP_SEL    8'h00
`define SSDB_OFS_DB_SET      8'h04
`define SSDB_OFS_DB_CLR      8'h08

// ************************************************************
// Reset values
// ************************************************************
`define SSDB_SUSP_SEL_RST    32'hffffffff
`define SSDB_DB_RST          4'h0

// ************************************************************
// Field positions of the suspend source register
// ************************************************************
`define SSDB_WIDE_TIMER_B    28
`define SSDB_WIDE_TIMER_A    27
`define SSDB_PWM_C           25
`define SSDB_PWM_B           24
`define SSDB_PWM_A           23
`define SSDB_SERIAL_PERIPH_B 22
`define SSDB_SERIAL_PERIPH_A 21
`define SSDB_ASYNC_SERIAL_C  20
`define SSDB_ASYNC_SERIAL_B  19
`define SSDB_ASYNC_SERIAL_A  18
`define SSDB_TWO_WIRE_B      17
`define SSDB_TWO_WIRE_A      16
`define SSDB_USB_CTRL        9
`define SSDB_REALTIME_UNIT   6
`define SSDB_ETHERNET        5
`define SSDB_ENCODER_B       4
`define SSDB_ENCODER_A       3
`define SSDB_CAPTURE_C       2
`define SSDB_CAPTURE_B       1
`define SSDB_CAPTURE_A       0

// Reserved bits of the suspend source register (31-29, 26, 15-10, 8-7)
`define SSDB_SUSP_RSVD_MASK  32'he400fd80

// ************************************************************
// Doorbell layout
// ************************************************************
`define SSDB_DB_BITS         4
`define SSDB_DB_RSVD_BIT     4

`endif

// ---- pkg/ssdb_pkg.sv ----
/*
 * Types of the suspend source and doorbell register bank.
 * Assumes ssdb_params.svh is reachable on the include path.
 */
`include "ssdb_params.svh"

package ssdb_pkg;

   // Peripheral suspend vector, one bit per register position
   typedef logic [31:0] ssdb_word_t;

   // Doorbell bits and their interrupt lines
   typedef logic [`SSDB_DB_BITS-1:0] ssdb_db_t;

   // States of the software-side command sequencer
   typedef enum logic [1:0] {
      SSDB_IDLE = 2'b00,
      SSDB_ISSUE = 2'b01,
      SSDB_WAIT = 2'b11
   } ssdb_state_t;

endpackage

// ---- pkg/ssdb_if.sv ----
/*
 * Carrier between the register bank and the software-side controller.
 * Assumes a single clock shared by both ends; no clocking block.
 */
`timescale 1ns/1ps

interface ssdb_if;
   import ssdb_pkg::*;

   logic [7:0]  addr;   // Byte address
   logic [31:0] wdata;  // Write data
   logic        wr;     // Write strobe, one cycle
   logic        rd;     // Read strobe, one cycle
   logic [31:0] rdata;  // Read data, cycle after rd

   modport bank (
      input  addr,
      input  wdata,
      input  wr,
      input  rd,
      output rdata
   );

   modport ctrl (
      output addr,
      output wdata,
      output wr,
      output rd,
      input  rdata
   );

endinterface

// ---- hw/ssdb_bank.sv ----
/*
 * Register bank: per-peripheral emulation suspend selectors and a
 * four-bit doorbell that drives four interrupt levels.
 * Assumes a master that keeps the plain strobe protocol of ssdb_if and
 * a debug suspend level that is already on the CLK domain.
 * Assumes software keeps the reserved selector bits at one and the
 * reserved doorbell bit at zero; the bank neither checks nor repairs
 * either, so a careless write is stored or dropped as it stands.
 */
`timescale 1ns/1ps

`include "ssdb_params.svh"

module ssdb_bank
   import ssdb_pkg::*;
(
   input  wire logic CLK,
   input  wire logic RSTN,
   ssdb_if.bank      BUS,
   input  wire logic DBG_SUSPEND,
   output logic      WIDE_TIMER_B_SUSP,
   output logic      WIDE_TIMER_A_SUSP,
   output logic      PWM_C_SUSP,
   output logic      PWM_B_SUSP,
   output logic      PWM_A_SUSP,
   output logic      SERIAL_PERIPH_B_SUSP,
   output logic      SERIAL_PERIPH_A_SUSP,
   output logic      ASYNC_SERIAL_C_SUSP,
   output logic      ASYNC_SERIAL_B_SUSP,
   output logic      ASYNC_SERIAL_A_SUSP,
   output logic      TWO_WIRE_B_SUSP,
   output logic      TWO_WIRE_A_SUSP,
   output logic      USB_CTRL_SUSP,
   output logic      REALTIME_UNIT_SUSP,
   output logic      ETHERNET_SUSP,
   output logic      ENCODER_B_SUSP,
   output logic      ENCODER_A_SUSP,
   output logic      CAPTURE_C_SUSP,
   output logic      CAPTURE_B_SUSP,
   output logic      CAPTURE_A_SUSP,
   output ssdb_db_t  DOORBELL_IRQ
);

   // ************************************************************
   // Storage and next values
   // ************************************************************
   // Every register and every output is a flop; the next values are
   // plain wires so each always_ff below stays a single load
   ssdb_word_t susp_sel_reg;
   ssdb_word_t susp_sel_next;
   ssdb_db_t   db_reg;
   ssdb_db_t   db_next;
   ssdb_word_t rdata_reg;
   ssdb_word_t rdata_next;
   ssdb_word_t susp_out_reg;
   ssdb_word_t susp_out_next;
   ssdb_db_t   irq_reg;

   // ************************************************************
   // Address decode
   // ************************************************************
   // Exact eight-bit compare; aliases would hide software bugs
   wire logic  hit_sel;
   wire logic  hit_set;
   wire logic  hit_clr;
   wire logic  wr_sel;
   wire logic  wr_set;
   wire logic  wr_clr;
   ssdb_db_t   set_mask;
   ssdb_db_t   clr_mask;

   assign hit_sel = (BUS.addr == `SSDB_OFS_SUSP_SEL);
   assign hit_set = (BUS.addr == `SSDB_OFS_DB_SET);
   assign hit_clr = (BUS.addr == `SSDB_OFS_DB_CLR);
   assign wr_sel  = BUS.wr & hit_sel;
   assign wr_set  = BUS.wr & hit_set;
   assign wr_clr  = BUS.wr & hit_clr;

   // ************************************************************
   // Suspend selector register
   // ************************************************************
   // All 32 bits store as written; reserved bits keep what software
   // writes back, which should be their ones default
   assign susp_sel_next = wr_sel ? BUS.wdata : susp_sel_reg;

   // A zero selector passes the debug suspend, a one holds it low;
   // reserved positions are gated too but reach no output
   assign susp_out_next = ~susp_sel_reg & {32{DBG_SUSPEND}};

   // ************************************************************
   // Doorbell set/clear
   // ************************************************************
   // Bit 4 upward is ignored on both writes
   // Masks are zero without a write, so an idle cycle holds every bit;
   // two masters hitting one bit at once still leave it set
   assign set_mask = wr_set ? BUS.wdata[`SSDB_DB_BITS-1:0] : `SSDB_DB_RST;
   assign clr_mask = wr_clr ? BUS.wdata[`SSDB_DB_BITS-1:0] : `SSDB_DB_RST;
   // Clear first, then set, so a set in the same cycle survives
   assign db_next = (db_reg & ~clr_mask) | set_mask;

   // ************************************************************
   // Read mux
   // ************************************************************
   // Clear register reads as zero; unmapped addresses read zero
   // Zero outside a read keeps the data lines quiet, so the master can
   // take the word without qualifying it beyond its own read strobe
   assign rdata_next = !BUS.rd  ? 32'h00000000 :
                       hit_sel  ? susp_sel_reg :
                       hit_set  ? {28'h0000000, db_reg} :
                                  32'h00000000;

   // Selector storage; reserved bits reset to one like the fields,
   // and stay there only while software writes those ones back
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         susp_sel_reg <= `SSDB_SUSP_SEL_RST;
      end else begin
         susp_sel_reg <= susp_sel_next;
      end
   end

   // Doorbell bits; the stored state is what software reads as
   // status and what the interrupt flop mirrors
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         db_reg <= `SSDB_DB_RST;
      end else begin
         db_reg <= db_next;
      end
   end

   // Read data flop; it holds zero outside the cycle after a read
   // so a stale word can never be mistaken for an answer
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Suspend outputs; one cycle behind the selector and the debug
   // level, which keeps the fan-out free of decode glitches
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         susp_out_reg <= 32'h00000000;
      end else begin
         susp_out_reg <= susp_out_next;
      end
   end

   // Interrupt levels; loaded from the same next value as the bits
   // so a line drops in the very cycle its bit is cleared
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         irq_reg <= `SSDB_DB_RST;
      end else begin
         irq_reg <= db_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Interrupt flop loads the same next value as the bit, so the level
   // tracks the stored bit cycle for cycle
   assign DOORBELL_IRQ = irq_reg;
   assign BUS.rdata    = rdata_reg;

   // Selector positions fan out to peripherals
   // Each output is one bit of the suspend flop, so a peripheral never
   // sees a combinational path from the bus
   assign WIDE_TIMER_B_SUSP    = susp_out_reg[`SSDB_WIDE_TIMER_B];
   assign WIDE_TIMER_A_SUSP    = susp_out_reg[`SSDB_WIDE_TIMER_A];
   assign PWM_C_SUSP           = susp_out_reg[`SSDB_PWM_C];
   assign PWM_B_SUSP           = susp_out_reg[`SSDB_PWM_B];
   assign PWM_A_SUSP           = susp_out_reg[`SSDB_PWM_A];
   assign SERIAL_PERIPH_B_SUSP = susp_out_reg[`SSDB_SERIAL_PERIPH_B];
   assign SERIAL_PERIPH_A_SUSP = susp_out_reg[`SSDB_SERIAL_PERIPH_A];
   assign ASYNC_SERIAL_C_SUSP  = susp_out_reg[`SSDB_ASYNC_SERIAL_C];
   assign ASYNC_SERIAL_B_SUSP  = susp_out_reg[`SSDB_ASYNC_SERIAL_B];
   assign ASYNC_SERIAL_A_SUSP  = susp_out_reg[`SSDB_ASYNC_SERIAL_A];
   assign TWO_WIRE_B_SUSP      = susp_out_reg[`SSDB_TWO_WIRE_B];
   assign TWO_WIRE_A_SUSP      = susp_out_reg[`SSDB_TWO_WIRE_A];
   assign USB_CTRL_SUSP        = susp_out_reg[`SSDB_USB_CTRL];
   assign REALTIME_UNIT_SUSP   = susp_out_reg[`SSDB_REALTIME_UNIT];
   assign ETHERNET_SUSP        = susp_out_reg[`SSDB_ETHERNET];
   assign ENCODER_B_SUSP       = susp_out_reg[`SSDB_ENCODER_B];
   assign ENCODER_A_SUSP       = susp_out_reg[`SSDB_ENCODER_A];
   assign CAPTURE_C_SUSP       = susp_out_reg[`SSDB_CAPTURE_C];
   assign CAPTURE_B_SUSP       = susp_out_reg[`SSDB_CAPTURE_B];
   assign CAPTURE_A_SUSP       = susp_out_reg[`SSDB_CAPTURE_A];

endmodule

// ---- hw/ssdb_ctrl.sv ----
/*
 * Software-side controller: takes one command at a time on a plain
 * port and turns it into a bus cycle toward the register bank.
 * Assumes the bank answers a read in the cycle after the strobe.
 */
`timescale 1ns/1ps

module ssdb_ctrl
   import ssdb_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RSTN,
   ssdb_if.ctrl             BUS,
   input  wire logic        CMD_VALID,
   input  wire logic        CMD_WRITE,
   input  wire logic [7:0]  CMD_ADDR,
   input  wire logic [31:0] CMD_WDATA,
   output logic             CMD_BUSY,
   output logic             RSP_VALID,
   output logic [31:0]      RSP_RDATA
);

   // ************************************************************
   // Sequencer
   // ************************************************************
   ssdb_state_t state_reg;
   ssdb_state_t state_next;
   logic [7:0]  addr_reg;
   logic [31:0] wdata_reg;
   logic        wr_reg;
   logic        rd_reg;
   logic        busy_reg;
   logic        rsp_reg;
   logic [31:0] rsp_data_reg;
   wire logic   take;

   // Accepted only when idle; busy blocks a second command
   assign take = (state_reg == SSDB_IDLE) & CMD_VALID;

   // Writes need one cycle, reads wait one more for the data
   always_comb begin
      case (state_reg)
         SSDB_IDLE:  state_next = take ? SSDB_ISSUE : SSDB_IDLE;
         SSDB_ISSUE: state_next = rd_reg ? SSDB_WAIT : SSDB_IDLE;
         SSDB_WAIT:  state_next = SSDB_IDLE;
         default:    state_next = SSDB_IDLE;
      endcase
   end

   // Bus strobes last exactly the ISSUE cycle
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         state_reg    <= SSDB_IDLE;
         addr_reg     <= 8'h00;
         wdata_reg    <= 32'h00000000;
         wr_reg       <= 1'b0;
         rd_reg       <= 1'b0;
         busy_reg     <= 1'b0;
         rsp_reg      <= 1'b0;
         rsp_data_reg <= 32'h00000000;
      end else begin
         state_reg <= state_next;
         wr_reg    <= take & CMD_WRITE;
         rd_reg    <= take & ~CMD_WRITE;
         busy_reg  <= (state_next != SSDB_IDLE);
         rsp_reg   <= (state_reg == SSDB_WAIT);
         if (take) begin
            addr_reg  <= CMD_ADDR;
            wdata_reg <= CMD_WDATA;
         end
         if (state_reg == SSDB_WAIT) begin
            rsp_data_reg <= BUS.rdata;
         end
      end
   end

   assign BUS.addr  = addr_reg;
   assign BUS.wdata = wdata_reg;
   assign BUS.wr    = wr_reg;
   assign BUS.rd    = rd_reg;
   assign CMD_BUSY  = busy_reg;
   assign RSP_VALID = rsp_reg;
   assign RSP_RDATA = rsp_data_reg;

endmodule

// ---- bench/ssdb_sva.sv ----
/* Concurrent checks on the bus between controller and register bank.
   Assumes one clock, sync active-low reset, offsets 00/04/08. */
`timescale 1ns/1ps

module ssdb_sva
   import ssdb_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata
);
   // ****************************************
   // Shadow registers
   // ****************************************
   logic [31:0] sel_reg;
   logic [3:0]  db_reg;

   // Follows bus writes so read data can be judged without the bank's internals
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         sel_reg <= 32'hffffffff;
         db_reg  <= 4'h0;
      end else if (wr && addr == 8'h00) begin
         sel_reg <= wdata;
      end else if (wr && addr == 8'h04) begin
         db_reg <= db_reg | wdata[3:0];
      end else if (wr && addr == 8'h08) begin
         db_reg <= db_reg & ~wdata[3:0];
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   sequence s_db_rd;
      rd && addr == 8'h04;
   endsequence
   sequence s_odd_rd;
      rd && addr != 8'h00 && addr != 8'h04 && addr != 8'h08;
   endsequence

   a_read_idle_zero: assert property (!rd |=> rdata == 32'h0)
      else $error("read data not zero outside a read");
   a_db_read_state: assert property (s_db_rd |=> rdata[3:0] == $past(db_reg))
      else $error("doorbell read differs from set and clear history");
   a_db_high_zero: assert property (s_db_rd |=> rdata[31:4] == 28'h0)
      else $error("doorbell upper bits not zero");
   a_clr_read_zero: assert property (rd && addr == 8'h08 |=> rdata == 32'h0)
      else $error("clear register read not zero");
   a_sel_readback: assert property (rd && addr == 8'h00 |=> rdata == $past(sel_reg))
      else $error("select readback differs from last write");
   a_unmapped_zero: assert property (s_odd_rd |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_strobe_excl: assert property (!(wr && rd))
      else $error("write and read strobes together");
   a_write_single: assert property (wr |=> !wr && !rd)
      else $error("write strobe not followed by an idle cycle");
endmodule

// ---- bench/suspend_source_and_doorbell_regs_tb.sv ----
/* Self-checking bench: controller and bank joined by ssdb_if.
   Assumes the command port contract of the controller. */
`timescale 1ns/1ps

module suspend_source_and_doorbell_regs_tb
   import ssdb_pkg::*;
;
   logic        clk = 1'b0;
   logic        rstn, dbg, cmd_valid, cmd_write, cmd_busy, rsp_valid;
   logic [7:0]  cmd_addr;
   logic [31:0] cmd_wdata, rsp_rdata;
   wire  [31:0] susp_vec;
   ssdb_db_t    irq;
   int          fail_count = 0;
   int          checked = 0;

   always #5 clk = ~clk;

   // ****************************************
   // Both ends, carrier and checker
   // ****************************************
   ssdb_if bus ();
   ssdb_ctrl ssdb_ctrl_inst (.CLK(clk), .RSTN(rstn), .BUS(bus), .CMD_VALID(cmd_valid),
      .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
      .CMD_BUSY(cmd_busy), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
   // Outputs land on their select bit positions; reserved positions tie low
   assign susp_vec[31:29] = 3'h0;
   assign susp_vec[26]    = 1'b0;
   assign susp_vec[15:10] = 6'h00;
   assign susp_vec[8:7]   = 2'h0;
   ssdb_bank ssdb_bank_inst (.CLK(clk), .RSTN(rstn), .BUS(bus), .DBG_SUSPEND(dbg),
      .WIDE_TIMER_B_SUSP(susp_vec[28]), .WIDE_TIMER_A_SUSP(susp_vec[27]),
      .PWM_C_SUSP(susp_vec[25]), .PWM_B_SUSP(susp_vec[24]), .PWM_A_SUSP(susp_vec[23]),
      .SERIAL_PERIPH_B_SUSP(susp_vec[22]), .SERIAL_PERIPH_A_SUSP(susp_vec[21]),
      .ASYNC_SERIAL_C_SUSP(susp_vec[20]), .ASYNC_SERIAL_B_SUSP(susp_vec[19]),
      .ASYNC_SERIAL_A_SUSP(susp_vec[18]), .TWO_WIRE_B_SUSP(susp_vec[17]),
      .TWO_WIRE_A_SUSP(susp_vec[16]), .USB_CTRL_SUSP(susp_vec[9]),
      .REALTIME_UNIT_SUSP(susp_vec[6]), .ETHERNET_SUSP(susp_vec[5]),
      .ENCODER_B_SUSP(susp_vec[4]), .ENCODER_A_SUSP(susp_vec[3]),
      .CAPTURE_C_SUSP(susp_vec[2]), .CAPTURE_B_SUSP(susp_vec[1]),
      .CAPTURE_A_SUSP(susp_vec[0]), .DOORBELL_IRQ(irq));
   ssdb_sva ssdb_sva_inst (.CLK(clk), .RSTN(rstn), .addr(bus.addr), .wdata(bus.wdata),
      .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One command; waits for busy to fall and, on a read, for the response
   task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      bit got;
      got = 1'b0;
      q = 32'h0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr  <= a;
      cmd_wdata <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (int n = 0; n < 10; n++) begin
         tick(1);
         if (rsp_valid === 1'b1) begin
            q = rsp_rdata;
            got = 1'b1;
         end
         if (cmd_busy === 1'b0 && (w || got)) begin
            chk("cmd_cycles", n, w ? 32'h0 : 32'h1);
            return;
         end
      end
      fail_count++;
      report_and_stop();
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Reset leaves every select at one, so no peripheral is suspended
   task automatic t_reset;
      logic [31:0] q;
      chk("susp_rst", susp_vec & 32'h1bff027f, 32'h0);
      cmd(1'b0, 8'h00, 32'h0, q);
      chk("sel_rst", q, 32'hffffffff);
      cmd(1'b0, 8'h04, 32'h0, q);
      chk("db_rst", q, 32'h0);
   endtask

   // One select cleared at a time must reach exactly its own output
   task automatic t_susp_map;
      int pos[20] = '{28, 27, 25, 24, 23, 22, 21, 20, 19, 18, 17, 16, 9, 6, 5, 4, 3, 2, 1, 0};
      logic [31:0] q;
      foreach (pos[i]) begin
         cmd(1'b1, 8'h00, ~(32'h1 << pos[i]), q);
         tick(2);
         chk("susp_map", susp_vec & 32'h1bff027f, 32'h1 << pos[i]);
      end
   endtask

   // All selects zero with reserved ones kept; suspend follows the debug level
   task automatic t_susp_all;
      logic [31:0] q;
      cmd(1'b1, 8'h00, 32'he400fd80, q);
      tick(2);
      chk("susp_all", susp_vec & 32'h1bff027f, 32'h1bff027f);
      cmd(1'b0, 8'h00, 32'h0, q);
      chk("sel_rd", q, 32'he400fd80);
      @(posedge clk);
      dbg <= 1'b0;
      tick(2);
      chk("susp_off", susp_vec & 32'h1bff027f, 32'h0);
      @(posedge clk);
      dbg <= 1'b1;
   endtask

   // Set bits one by one, then clear some; zero writes change nothing
   task automatic t_doorbell;
      logic [31:0] q;
      logic [3:0]  e;
      e = 4'h0;
      for (int i = 0; i < 4; i++) begin
         cmd(1'b1, 8'h04, 32'h1 << i, q);
         e = e | (4'h1 << i);
         chk("irq_set", {28'h0, irq}, {28'h0, e});
         cmd(1'b0, 8'h04, 32'h0, q);
         chk("db_read", q, {28'h0, e});
      end
      cmd(1'b1, 8'h04, 32'h0, q);
      cmd(1'b1, 8'h08, 32'h0, q);
      chk("irq_keep", {28'h0, irq}, 32'hf);
      cmd(1'b1, 8'h08, 32'h5, q);
      tick(1);
      chk("irq_clr", {28'h0, irq}, 32'ha);
      cmd(1'b0, 8'h08, 32'h0, q);
      chk("clr_read", q, 32'h0);
      cmd(1'b1, 8'h08, 32'ha, q);
      cmd(1'b0, 8'h04, 32'h0, q);
      chk("db_done", q, 32'h0);
   endtask

   // Unmapped address: write ignored, read zero
   task automatic t_unmapped;
      logic [31:0] q;
      cmd(1'b1, 8'h0c, 32'h0, q);
      cmd(1'b0, 8'h0c, 32'h0, q);
      chk("odd_read", q, 32'h0);
      cmd(1'b0, 8'h00, 32'h0, q);
      chk("sel_kept", q, 32'he400fd80);
   endtask

   initial begin
      rstn = 1'b0;
      dbg = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 8'h00;
      cmd_wdata = 32'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      tick(1);
      t_reset();
      t_susp_map();
      t_susp_all();
      t_doorbell();
      t_unmapped();
      report_and_stop();
   end
endmodule
